// ===== cmd_defs.svh
// constants for the counter mode decode and frequency scaler block
// assumes one 125 MHz clock; included by the package and both design modules
`ifndef CMD_DEFS_SVH
`define CMD_DEFS_SVH

// clock rate, for reference by the bench
`define CMD_CLK_MHZ 125

// gate control field codes
`define CMD_GC_NONE 3'h0
`define CMD_GC_LEVEL 3'h4
`define CMD_GC_EDGE 3'h6

// count value that marks the terminal count state
`define CMD_TC_COUNT 16'h0001
`define CMD_COUNT_RST 16'h0000
`define CMD_HOLD_RST 16'h0000

// frequency scaler stage limits
`define CMD_STAGES 4
`define CMD_DIGIT_RST 4'h0
`define CMD_DIGIT_BIN_LAST 4'hF
`define CMD_DIGIT_DEC_LAST 4'h9

`endif

// ===== cmd_pkg.sv
// types shared by the counter mode decode and scaler modules
// assumes cmd_defs.svh is on the include path
`default_nettype none
`include "cmd_defs.svh"

package cmd_pkg;
    typedef logic [15:0] cmd_word_t;
    typedef logic [3:0] cmd_digit_t;
    // decoded gating style, one-hot
    typedef enum logic [2:0] {
        CMD_GK_FREE = 3'h1,
        CMD_GK_LEVEL = 3'h2,
        CMD_GK_EDGE = 3'h4
    } cmd_gate_kind_t;
endpackage

`default_nettype wire

// ===== cmd_stage_if.sv
// carry link between one scaler stage and the chain around it
// assumes all signals live in the single clk_i domain
`default_nettype none

interface cmd_stage_if;
    logic decimal;
    logic carry_in;
    logic carry_out;
    modport stage (input decimal, input carry_in, output carry_out);
    modport chain (output decimal, output carry_in, input carry_out);
endinterface

`default_nettype wire

// ===== cmd_scaler_stage.sv
// one digit of the frequency scaler: counts mod 16 or mod 10
// assumes carry_in is a one-cycle enable from the previous stage
`default_nettype none
`include "cmd_defs.svh"

module cmd_scaler_stage
    import cmd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    cmd_stage_if.stage lnk
);
    cmd_digit_t digit_r;
    cmd_digit_t digit_nxt;
    wire cmd_digit_t last_w;
    wire wrap_w;

    // binary or decimal limit picked by the ratio select
    assign last_w = lnk.decimal ? `CMD_DIGIT_DEC_LAST : `CMD_DIGIT_BIN_LAST;
    assign wrap_w = lnk.carry_in & (digit_r == last_w);
    assign lnk.carry_out = wrap_w;
    // a digit above 9 after switching to decimal wraps on the next enable
    assign digit_nxt = !lnk.carry_in ? digit_r :
                       (digit_r >= last_w) ? `CMD_DIGIT_RST : digit_r + 4'h1;

    // digit register
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            digit_r <= `CMD_DIGIT_RST;
        else
            digit_r <= digit_nxt;
    end

    a_stage_binary: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!lnk.decimal && lnk.carry_out) |-> (digit_r == 4'hF) ##1 (digit_r == 4'h0))
        else $error("binary stage carried at wrong digit");
    a_stage_decimal: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (lnk.decimal && lnk.carry_in && digit_r == 4'h9) |-> lnk.carry_out ##1 (digit_r == 4'h0))
        else $error("decimal stage did not wrap after nine");
endmodule

`default_nettype wire

// ===== cmd_counter.sv
// counter mode decode, gating, reload and hold logic for one 16-bit counter,
// plus the shared frequency scaler chain
// assumes gate and source pins are asynchronous; host controls are clk_i synchronous
`default_nettype none
`include "cmd_defs.svh"

module cmd_counter
    import cmd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic scaler_ratio_select_i,
    input wire logic [2:0] gate_control_field_i,
    input wire logic special_gate_bit_i,
    input wire logic reload_source_bit_i,
    input wire logic repetition_bit_i,
    input wire logic source_i,
    input wire logic gate_i,
    input wire logic arm_i,
    input wire logic disarm_i,
    input wire logic load_cmd_i,
    input wire logic [15:0] load_value_i,
    input wire logic hold_wr_i,
    input wire logic [15:0] hold_data_i,
    output logic [15:0] count_o,
    output logic [15:0] hold_o,
    output logic armed_o,
    output logic terminal_count_o,
    output logic [3:0] scaler_tick_o
);
    // pin synchronisers and edge history
    logic src_m_r, src_s_r, src_d_r;
    logic gate_m_r, gate_s_r, gate_d_r;
    cmd_word_t count_r, count_nxt;
    cmd_word_t hold_r, hold_nxt;
    logic armed_r, armed_nxt;
    logic run_r, run_nxt;
    logic alt_r, alt_nxt;
    logic tc_r;
    logic [3:0] tick_r;
    cmd_gate_kind_t gate_kind_w;

    // field decode
    wire sg_w = special_gate_bit_i;
    wire rs_w = reload_source_bit_i;
    wire rp_w = repetition_bit_i;
    // codes outside the three documented ones act as ungated
    assign gate_kind_w = (gate_control_field_i == `CMD_GC_LEVEL) ? CMD_GK_LEVEL :
                         (gate_control_field_i == `CMD_GC_EDGE) ? CMD_GK_EDGE : CMD_GK_FREE;
    wire edge_mode_w = gate_kind_w == CMD_GK_EDGE;
    wire level_mode_w = gate_kind_w == CMD_GK_LEVEL;
    wire free_mode_w = gate_kind_w == CMD_GK_FREE;
    wire once_mode_w = !rs_w & !rp_w;
    wire twice_mode_w = rs_w & !rp_w;
    wire pair_mode_w = !sg_w & rs_w;
    wire gsel_mode_w = sg_w & rs_w & free_mode_w;
    wire retrig_mode_w = sg_w & !rs_w & !free_mode_w;
    wire capx_mode_w = sg_w & rs_w & rp_w & edge_mode_w;
    wire second_stop_w = pair_mode_w | twice_mode_w;

    // events seen on the synchronised pins
    wire src_rise_w = src_s_r & !src_d_r;
    wire gate_rise_w = gate_s_r & !gate_d_r;

    // a counter sitting in terminal count always takes the next edge
    wire leave_tc_w = tc_r & src_rise_w;
    wire gate_ok_w = free_mode_w | (level_mode_w & gate_s_r) | (edge_mode_w & run_r);
    wire count_en_w = src_rise_w & armed_r & gate_ok_w;
    // only special-gate modes react to an edge beyond starting a count
    wire retrig_w = gate_rise_w & armed_r & retrig_mode_w;
    wire capture_w = gate_rise_w & armed_r & (retrig_mode_w | capx_mode_w);
    wire start_w = gate_rise_w & armed_r & edge_mode_w;
    wire disarm_tc_w = leave_tc_w & (once_mode_w | (twice_mode_w & alt_r));
    wire stop_tc_w = leave_tc_w & (!second_stop_w | alt_r);

    // reload source on leaving terminal count
    wire cmd_word_t reload_w = pair_mode_w ? (alt_r ? load_value_i : hold_r) :
                               gsel_mode_w ? (gate_s_r ? hold_r : load_value_i) :
                               load_value_i;

    // next count: host load, then terminal reload, then retrigger, then decrement
    assign count_nxt = load_cmd_i ? load_value_i :
                       leave_tc_w ? reload_w :
                       retrig_w ? load_value_i :
                       count_en_w ? count_r - 16'h0001 : count_r;
    // hardware capture wins over a host write in the same cycle
    assign hold_nxt = capture_w ? count_r : hold_wr_i ? hold_data_i : hold_r;
    // arm command wins over any clear arriving with it
    assign armed_nxt = arm_i | (armed_r & !disarm_i & !disarm_tc_w);
    assign run_nxt = (start_w | (run_r & !stop_tc_w)) & armed_nxt;
    assign alt_nxt = arm_i ? 1'b0 : (leave_tc_w & second_stop_w) ? !alt_r : alt_r;

    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            src_m_r <= 1'b0;
            src_s_r <= 1'b0;
            src_d_r <= 1'b0;
            gate_m_r <= 1'b0;
            gate_s_r <= 1'b0;
            gate_d_r <= 1'b0;
        end
        else
        begin
            src_m_r <= source_i;
            src_s_r <= src_m_r;
            src_d_r <= src_s_r;
            gate_m_r <= gate_i;
            gate_s_r <= gate_m_r;
            gate_d_r <= gate_s_r;
        end
    end

    // counter state
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            count_r <= `CMD_COUNT_RST;
            hold_r <= `CMD_HOLD_RST;
            armed_r <= 1'b0;
            run_r <= 1'b0;
            alt_r <= 1'b0;
            tc_r <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            hold_r <= hold_nxt;
            armed_r <= armed_nxt;
            run_r <= run_nxt;
            alt_r <= alt_nxt;
            tc_r <= (count_nxt == `CMD_TC_COUNT);
        end
    end

    // scaler chain: clk_i is the oscillator, each stage feeds the next
    logic [`CMD_STAGES:0] carry_w;
    assign carry_w[0] = 1'b1;
    genvar gi;
    generate
        for (gi = 0; gi < `CMD_STAGES; gi = gi + 1)
        begin : g_stage
            cmd_stage_if lnk ();
            assign lnk.decimal = scaler_ratio_select_i;
            assign lnk.carry_in = carry_w[gi];
            assign carry_w[gi + 1] = lnk.carry_out;
            cmd_scaler_stage u_stage (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .lnk(lnk)
            );
        end
    endgenerate

    // registered subfrequency ticks, one cycle each
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tick_r <= 4'h0;
        else
            tick_r <= carry_w[`CMD_STAGES:1];
    end

    assign count_o = count_r;
    assign hold_o = hold_r;
    assign armed_o = armed_r;
    assign terminal_count_o = tc_r;
    assign scaler_tick_o = tick_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_once_disarm: assert property ((!sg_w && once_mode_w && leave_tc_w && !arm_i) |=> !armed_r)
        else $error("single-shot mode stayed armed after terminal count");
    a_twice_disarm: assert property ((!sg_w && twice_mode_w && leave_tc_w && !arm_i)
        |=> (armed_r == !$past(alt_r)))
        else $error("two-shot mode disarmed at the wrong terminal count");
    a_repeat_armed: assert property ((rp_w && armed_r && !disarm_i) |=> armed_r)
        else $error("repeating mode disarmed itself");
    a_free_count: assert property ((free_mode_w && armed_r && src_rise_w && !tc_r && !load_cmd_i
        && !retrig_w) |=> count_r == $past(count_r) - 16'h0001)
        else $error("ungated counter missed a source edge");
    a_level_block: assert property ((level_mode_w && !gate_s_r && !tc_r && !load_cmd_i)
        |=> $stable(count_r))
        else $error("level-gated counter moved with gate low");
    a_edge_stop: assert property ((edge_mode_w && !second_stop_w && leave_tc_w && !gate_rise_w)
        |=> !run_r)
        else $error("edge mode kept running after terminal count");
    a_edge_second: assert property ((edge_mode_w && pair_mode_w && run_r && leave_tc_w && !alt_r
        && !disarm_i && !arm_i) |=> run_r ##0 alt_r)
        else $error("edge mode stopped at first terminal count");
    a_reload_load: assert property ((!pair_mode_w && !gsel_mode_w && leave_tc_w && !load_cmd_i)
        |=> count_r == $past(load_value_i))
        else $error("terminal reload did not use load value");
    a_reload_alt: assert property ((pair_mode_w && leave_tc_w && !load_cmd_i)
        |=> count_r == ($past(alt_r) ? $past(load_value_i) : $past(hold_r)))
        else $error("alternating reload took the wrong source");
    a_reload_gate: assert property ((gsel_mode_w && leave_tc_w && gate_s_r && !load_cmd_i)
        |=> count_r == $past(hold_r))
        else $error("gate-high terminal reload did not use hold");
    a_retrig_cap: assert property ((retrig_mode_w && armed_r && gate_rise_w && !leave_tc_w
        && !load_cmd_i) |=> (hold_r == $past(count_r)) && (count_r == $past(load_value_i)))
        else $error("retrigger did not capture and reload");
    a_capture_x: assert property ((capx_mode_w && armed_r && gate_rise_w && !tc_r && !load_cmd_i
        && !count_en_w) |=> (hold_r == $past(count_r)) && $stable(count_r))
        else $error("mode X capture disturbed the count");
    a_no_retrig: assert property ((!sg_w && gate_rise_w && !hold_wr_i && !tc_r && !load_cmd_i
        && !count_en_w) |=> $stable(hold_r) && $stable(count_r))
        else $error("gate edge retriggered a non-retriggerable mode");
    a_tc_leave: assert property ((tc_r && !src_rise_w && armed_r && !disarm_i)
        |=> armed_r && (run_r || !$past(run_r)))
        else $error("counter stopped or disarmed before leaving terminal count");
endmodule

`default_nettype wire

// ===== cmd_pin_model.sv
// model of the external source and gate pins seen by the counter
// assumes the bench calls its tasks; pins change just after clk_i rises
`default_nettype none

module cmd_pin_model (
    input wire logic clk_i,
    output logic source_o,
    output logic gate_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // pins idle low
    initial
    begin
        source_o = 1'b0;
        gate_o = 1'b0;
    end

    // source pulses wider than two clocks, so the synchroniser never drops one
    task automatic src(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            source_o <= 1'b1;
            repeat (3) @(posedge clk_i);
            source_o <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask

    // gate level change, then time for the pin event to land
    task automatic gate(input logic v);
        @(posedge clk_i);
        gate_o <= v;
        repeat (6) @(posedge clk_i);
    endtask
endmodule

`default_nettype wire

// ===== cmd_counter_test.sv
// self-checking bench for the counter mode decode and scaler block
// assumes cmd_defs.svh on the include path and cmd_pin_model as pin partner
`default_nettype none
`include "cmd_defs.svh"

module cmd_counter_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i = 1'b0;
    logic rst_n_i;
    logic ratio;
    logic [2:0] gc;
    logic sg;
    logic rs;
    logic rp;
    logic arm;
    logic dis;
    logic ld;
    logic hw;
    logic [15:0] lv;
    logic [15:0] hd;
    wire logic source;
    wire logic gate;
    logic [15:0] count;
    logic [15:0] hold;
    logic armed;
    logic tc;
    logic [3:0] tick;
    int n_errors = 0;
    int tests_run = 0;

    cmd_counter dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .scaler_ratio_select_i(ratio),
        .gate_control_field_i(gc), .special_gate_bit_i(sg), .reload_source_bit_i(rs),
        .repetition_bit_i(rp), .source_i(source), .gate_i(gate), .arm_i(arm), .disarm_i(dis),
        .load_cmd_i(ld), .load_value_i(lv), .hold_wr_i(hw), .hold_data_i(hd), .count_o(count),
        .hold_o(hold), .armed_o(armed), .terminal_count_o(tc), .scaler_tick_o(tick));
    cmd_pin_model pm_u (.clk_i(clk_i), .source_o(source), .gate_o(gate));

    // 125 MHz clock
    initial
    begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic chk(input logic [15:0] c, input logic a);
        cmp16(count, c);
        cmp1(armed, a);
    endtask

    // stop, program a defined mode, load, write hold, arm
    task automatic setup(input logic [2:0] g, input logic [2:0] b, input logic [15:0] l,
        input logic [15:0] h);
        pm_u.gate(1'b0);
        dis <= 1'b1;
        gc <= g;
        sg <= b[2];
        rs <= b[1];
        rp <= b[0];
        lv <= l;
        hd <= h;
        @(posedge clk_i);
        dis <= 1'b0;
        ld <= 1'b1;
        hw <= 1'b1;
        arm <= 1'b1;
        @(posedge clk_i);
        ld <= 1'b0;
        hw <= 1'b0;
        arm <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    // clocks between two ticks of one scaler output
    task automatic t_scaler(input logic r, input int b, input logic [15:0] per);
        logic [15:0] n;
        ratio <= r;
        @(posedge clk_i iff tick[b]);
        @(posedge clk_i iff tick[b]);
        n = 16'h0000;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (tick[b] !== 1'b1 && n < 16'h1000);
        cmp16(n, per);
    endtask

    task automatic t_mode_a;
        setup(`CMD_GC_NONE, 3'h0, 16'h0003, 16'h0000);
        pm_u.src(2);
        chk(16'h0001, 1'b1);
        cmp1(tc, 1'b1);
        pm_u.src(1);
        chk(16'h0003, 1'b0);
        pm_u.src(1);
        chk(16'h0003, 1'b0);
    endtask

    task automatic t_mode_d;
        setup(`CMD_GC_NONE, 3'h1, 16'h0002, 16'h0000);
        pm_u.gate(1'b1);
        pm_u.src(1);
        chk(16'h0001, 1'b1);
        pm_u.gate(1'b0);
        pm_u.src(1);
        chk(16'h0002, 1'b1);
    endtask

    task automatic t_mode_b;
        setup(`CMD_GC_LEVEL, 3'h0, 16'h0005, 16'h0000);
        pm_u.src(1);
        chk(16'h0005, 1'b1);
        pm_u.gate(1'b1);
        pm_u.src(1);
        chk(16'h0004, 1'b1);
    endtask

    task automatic t_mode_g;
        setup(`CMD_GC_NONE, 3'h2, 16'h0002, 16'h0003);
        pm_u.src(2);
        chk(16'h0003, 1'b1);
        pm_u.src(2);
        chk(16'h0001, 1'b1);
        pm_u.src(1);
        chk(16'h0002, 1'b0);
    endtask

    // edge start; a second gate edge must not restart the count
    task automatic t_mode_c;
        setup(`CMD_GC_EDGE, 3'h0, 16'h0003, 16'h0000);
        pm_u.src(1);
        chk(16'h0003, 1'b1);
        pm_u.gate(1'b1);
        pm_u.src(1);
        pm_u.gate(1'b0);
        pm_u.gate(1'b1);
        chk(16'h0002, 1'b1);
        pm_u.src(2);
        chk(16'h0003, 1'b0);
    endtask

    task automatic t_mode_i;
        setup(`CMD_GC_EDGE, 3'h2, 16'h0002, 16'h0004);
        pm_u.gate(1'b1);
        pm_u.src(2);
        chk(16'h0004, 1'b1);
        pm_u.src(4);
        chk(16'h0002, 1'b0);
    endtask

    task automatic t_mode_r;
        setup(`CMD_GC_EDGE, 3'h5, 16'h0005, 16'h0000);
        pm_u.gate(1'b1);
        pm_u.src(2);
        pm_u.gate(1'b0);
        pm_u.gate(1'b1);
        cmp16(hold, 16'h0003);
        chk(16'h0005, 1'b1);
    endtask

    task automatic t_mode_x;
        setup(`CMD_GC_EDGE, 3'h7, 16'h0005, 16'h0000);
        pm_u.gate(1'b1);
        pm_u.src(2);
        pm_u.gate(1'b0);
        pm_u.gate(1'b1);
        cmp16(hold, 16'h0003);
        pm_u.src(1);
        chk(16'h0002, 1'b1);
    endtask

    task automatic t_mode_v;
        setup(`CMD_GC_NONE, 3'h7, 16'h0002, 16'h0003);
        pm_u.gate(1'b1);
        pm_u.src(2);
        chk(16'h0003, 1'b1);
        pm_u.src(2);
        pm_u.gate(1'b0);
        pm_u.src(1);
        chk(16'h0002, 1'b1);
    endtask

    // level gating plus retrigger; single terminal count disarms
    task automatic t_mode_n;
        setup(`CMD_GC_LEVEL, 3'h4, 16'h0005, 16'h0000);
        pm_u.src(1);
        chk(16'h0005, 1'b1);
        pm_u.gate(1'b1);
        pm_u.src(2);
        pm_u.gate(1'b0);
        pm_u.gate(1'b1);
        cmp16(hold, 16'h0003);
        chk(16'h0005, 1'b1);
        pm_u.src(4);
        chk(16'h0001, 1'b1);
        pm_u.src(1);
        chk(16'h0005, 1'b0);
    endtask

    // edge start, alternating reload, stops at second terminal count but stays armed
    task automatic t_mode_l;
        setup(`CMD_GC_EDGE, 3'h3, 16'h0002, 16'h0003);
        pm_u.gate(1'b1);
        pm_u.src(2);
        chk(16'h0003, 1'b1);
        pm_u.src(3);
        chk(16'h0002, 1'b1);
        pm_u.src(1);
        chk(16'h0002, 1'b1);
    endtask

    // reload source follows gate; two terminal counts then disarm
    task automatic t_mode_s;
        setup(`CMD_GC_NONE, 3'h6, 16'h0002, 16'h0004);
        pm_u.src(2);
        chk(16'h0002, 1'b1);
        pm_u.gate(1'b1);
        pm_u.src(2);
        chk(16'h0004, 1'b0);
    endtask

    // host disarm stops counting until a fresh arm
    task automatic t_disarm;
        setup(`CMD_GC_NONE, 3'h1, 16'h0004, 16'h0000);
        pm_u.src(1);
        chk(16'h0003, 1'b1);
        dis <= 1'b1;
        @(posedge clk_i);
        dis <= 1'b0;
        repeat (2) @(posedge clk_i);
        pm_u.src(1);
        chk(16'h0003, 1'b0);
        arm <= 1'b1;
        @(posedge clk_i);
        arm <= 1'b0;
        repeat (2) @(posedge clk_i);
        pm_u.src(1);
        chk(16'h0002, 1'b1);
    endtask

    // reset in mid-run clears everything; counter needs an arm afterwards
    task automatic t_reset;
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(16'h0000, 1'b0);
        cmp16(hold, 16'h0000);
        cmp1(tc, 1'b0);
        cmp16({12'h000, tick}, 16'h0000);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        pm_u.src(1);
        chk(16'h0000, 1'b0);
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // main sequence after a 20-cycle reset
    initial
    begin
        rst_n_i <= 1'b0;
        ratio <= 1'b0;
        gc <= `CMD_GC_NONE;
        sg <= 1'b0;
        rs <= 1'b0;
        rp <= 1'b0;
        arm <= 1'b0;
        dis <= 1'b0;
        ld <= 1'b0;
        hw <= 1'b0;
        lv <= 16'h0000;
        hd <= 16'h0000;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        t_scaler(1'b0, 0, 16'h0010);
        t_scaler(1'b0, 1, 16'h0100);
        t_scaler(1'b1, 0, 16'h000A);
        t_scaler(1'b1, 1, 16'h0064);
        t_scaler(1'b1, 2, 16'h03E8);
        t_mode_a();
        t_mode_d();
        t_mode_b();
        t_mode_g();
        t_mode_c();
        t_mode_i();
        t_mode_r();
        t_mode_x();
        t_mode_v();
        t_mode_n();
        t_mode_l();
        t_mode_s();
        t_disarm();
        t_reset();
        conclude();
    end

    // hang guard, well beyond the expected few thousand cycles
    initial
    begin
        #400000;
        n_errors++;
        conclude();
    end
endmodule

`default_nettype wire
